// >>> rtl/instr_exec.sv
// Purpose: executes the logic, move, return, config and sleep instructions
// Assumes: one instruction cycle every CLK_PER_INSTR core clocks
// Notes:   software posts an instruction word; it runs on the next tick
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps

// Function
// RULE1: or literal into accumulator, update null flag
// RULE2: or file into accumulator or file, null flag
// RULE3: store accumulator into file, flags unchanged
// RULE4: load file to accumulator or itself, null flag
// RULE5: self load still evaluates the null flag
// RULE6: load literal into accumulator, flags unchanged
// RULE7: config load copies accumulator, flags unchanged
// RULE8: return literal loads accumulator, pc from stack
// RULE9: return literal takes two instruction cycles
// RULE10: sleep clears watchdog counter and prescaler
// RULE11: sleep sets expiry, clears sleep, keeps pinwake
// RULE12: after sleep core halts until wake event
// RULE13: nop changes nothing but advances pc
module instr_exec
  import exec_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // wake pin and core state
  input  wire logic        WAKE_PIN_I,
  output logic             SLEEP_O,
  output logic             BUSY_O
);

  exec_state_t            state_q;
  logic [1:0]             div_q;
  logic                   tick;
  logic [INSTR_W-1:0]     instr_q;
  logic                   pend_q;
  logic [DATA_W-1:0]      acc_q;
  logic [DATA_W-1:0]      config_q;
  logic [PC_W-1:0]        pc_q;
  logic [PC_W-1:0]        stack_top_q;
  logic [DATA_W-1:0]      watchdog_counter_q;
  logic [DATA_W-1:0]      presc_q;
  logic                   null_flag_q;
  logic                   sleep_entered_flag_n_q;
  logic                   watchdog_expiry_flag_n_q;
  logic                   pin_wake_flag_q;
  logic [DATA_W-1:0]      file_q [32];
  logic                   ack_q;
  logic [31:0]            rdat_q;
  logic                   bus_req;
  logic                   wr_stb;
  logic                   exec_go;
  logic                   wake;
  logic [3:0]             opc;
  logic [DATA_W-1:0]      lit;
  logic [FADR_W-1:0]      fadr;
  logic                   dest_file;
  logic [DATA_W-1:0]      fval;
  logic [DATA_W-1:0]      res;
  logic [31:0]            rd_data;

  // true for the ops whose result feeds the null flag
  function automatic logic sets_null(input logic [3:0] op);
    return (op == OPC_OR_LIT) || (op == OPC_OR_FILE) || (op == OPC_LOAD_F);
  endfunction

  // true for the ops that may write their result into a file register
  function automatic logic file_dest(input logic [3:0] op);
    return (op == OPC_OR_FILE) || (op == OPC_LOAD_F);
  endfunction

  // instruction field extraction
  assign opc       = instr_q[OPC_MSB:OPC_LSB];
  assign lit       = instr_q[DATA_W-1:0];
  assign fadr      = instr_q[FADR_MSB:0];
  assign dest_file = instr_q[DEST_BIT];
  assign fval      = file_q[fadr];

  // bus strobes: a write acts on the edge that raises ack
  assign bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr_stb  = bus_req & WB_WE_I & WB_SEL_I[0];

  // one instruction per tick, only when awake and not in the flush slot
  assign exec_go = tick & pend_q & (state_q == ST_IDLE);

  // wake from software or pin, only meaningful while asleep
  assign wake = (state_q == ST_ASLEEP) &
                (WAKE_PIN_I | (wr_stb & (WB_ADR_I == OFS_CTRL) &
                               WB_DAT_I[CT_WAKE]));

  // result of the or and load paths
  always_comb begin
    res = fval;
    case (opc)
      OPC_OR_LIT:  res = acc_q | lit; // RULE1
      OPC_OR_FILE: res = acc_q | fval; // RULE2
      default:     res = fval; // RULE4
    endcase
  end

  // instruction cycle divider; it stops in sleep like the oscillator
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      div_q <= 2'h0;
    end else if (state_q == ST_ASLEEP) begin
      div_q <= 2'h0; // RULE12
    end else if (div_q == DIV_LAST) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign tick = (div_q == DIV_LAST) & (state_q != ST_ASLEEP);

  // posted instruction; a post while busy or asleep is dropped
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      instr_q <= 12'h000;
      pend_q  <= 1'b0;
    end else if (exec_go) begin
      pend_q <= 1'b0;
    end else if (wr_stb && WB_ADR_I == OFS_INSTR && !pend_q &&
                 state_q == ST_IDLE) begin
      instr_q <= WB_DAT_I[INSTR_W-1:0];
      pend_q  <= 1'b1;
    end
  end

  // sequencer: flush slot after return, halt after sleep
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (exec_go && opc == OPC_RET_LIT) begin
            state_q <= ST_FLUSH; // RULE9
          end else if (exec_go && opc == OPC_SLEEP) begin
            state_q <= ST_ASLEEP; // RULE12
          end
        end
        ST_FLUSH: begin
          if (tick) begin
            state_q <= ST_IDLE; // RULE9
          end
        end
        ST_ASLEEP: begin
          if (wake) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // accumulator; execution wins over a bus write in the same cycle
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc_q <= ACC_RST;
    end else if (exec_go && (opc == OPC_OR_LIT ||
                 (file_dest(opc) && !dest_file))) begin
      acc_q <= res; // RULE1 RULE2 RULE4
    end else if (exec_go && opc == OPC_LOAD_LIT) begin
      acc_q <= lit; // RULE6
    end else if (exec_go && opc == OPC_RET_LIT) begin
      acc_q <= lit; // RULE8
    end else if (wr_stb && WB_ADR_I == OFS_ACC) begin
      acc_q <= WB_DAT_I[DATA_W-1:0];
    end
  end

  // file registers, 32 bytes; bus reaches them in the upper half
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < 32; i++) begin
        file_q[i] <= FILE_RST;
      end
    end else if (exec_go && opc == OPC_STORE) begin
      file_q[fadr] <= acc_q; // RULE3
    end else if (exec_go && file_dest(opc) && dest_file) begin
      file_q[fadr] <= res; // RULE2 RULE4
    end else if (wr_stb && WB_ADR_I[FILE_SEL_BIT]) begin
      file_q[WB_ADR_I[6:2]] <= WB_DAT_I[DATA_W-1:0];
    end
  end

  // prescaler configuration register
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      config_q <= CONFIG_RST;
    end else if (exec_go && opc == OPC_CONFIG) begin
      config_q <= acc_q; // RULE7
    end
  end

  // program counter and return address
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pc_q <= PC_RST;
    end else if (exec_go && opc == OPC_RET_LIT) begin
      pc_q <= stack_top_q; // RULE8
    end else if (exec_go) begin
      pc_q <= pc_q + 9'h001; // RULE13
    end else if (wr_stb && WB_ADR_I == OFS_PC) begin
      pc_q <= WB_DAT_I[PC_W-1:0];
    end
  end

  // single stack level; popping leaves the entry in place
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      stack_top_q <= PC_RST;
    end else if (wr_stb && WB_ADR_I == OFS_STACK) begin
      stack_top_q <= WB_DAT_I[PC_W-1:0];
    end
  end

  // watchdog: prescaler counts ticks, counter counts its wraps
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      watchdog_counter_q <= WDOG_CLR;
      presc_q            <= WDOG_CLR;
    end else if (exec_go && opc == OPC_SLEEP) begin
      watchdog_counter_q <= WDOG_CLR; // RULE10
      presc_q            <= WDOG_CLR; // RULE10
    end else if (tick) begin
      presc_q <= presc_q + 8'h01;
      if (presc_q == PRESC_MAX) begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
    end
  end

  // status flags; any hardware update beats a software write
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      null_flag_q              <= 1'b0;
      sleep_entered_flag_n_q   <= 1'b1;
      watchdog_expiry_flag_n_q <= 1'b1;
      pin_wake_flag_q          <= 1'b0;
    end else if (exec_go && sets_null(opc)) begin
      null_flag_q <= (res == 8'h00); // RULE1 RULE2 RULE4 RULE5
    end else if (exec_go && opc == OPC_SLEEP) begin
      watchdog_expiry_flag_n_q <= 1'b1; // RULE11
      sleep_entered_flag_n_q   <= 1'b0; // RULE11
    end else if (wake && WAKE_PIN_I) begin
      pin_wake_flag_q <= 1'b1;
    end else if (wr_stb && WB_ADR_I == OFS_STATUS && !exec_go) begin
      null_flag_q              <= WB_DAT_I[ST_NULL];
      sleep_entered_flag_n_q   <= WB_DAT_I[ST_SLEEP_N];
      watchdog_expiry_flag_n_q <= WB_DAT_I[ST_EXPIRY_N];
      pin_wake_flag_q          <= WB_DAT_I[ST_PINWAKE];
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (WB_ADR_I[FILE_SEL_BIT]) begin
      rd_data[DATA_W-1:0] = file_q[WB_ADR_I[6:2]];
    end else if (WB_ADR_I == OFS_INSTR) begin
      rd_data[INSTR_W-1:0] = instr_q;
    end else if (WB_ADR_I == OFS_ACC) begin
      rd_data[DATA_W-1:0] = acc_q;
    end else if (WB_ADR_I == OFS_STATUS) begin
      rd_data[ST_NULL]     = null_flag_q;
      rd_data[ST_SLEEP_N]  = sleep_entered_flag_n_q;
      rd_data[ST_EXPIRY_N] = watchdog_expiry_flag_n_q;
      rd_data[ST_PINWAKE]  = pin_wake_flag_q;
    end else if (WB_ADR_I == OFS_CONFIG) begin
      rd_data[DATA_W-1:0] = config_q;
    end else if (WB_ADR_I == OFS_PC) begin
      rd_data[PC_W-1:0] = pc_q;
    end else if (WB_ADR_I == OFS_STACK) begin
      rd_data[PC_W-1:0] = stack_top_q;
    end else if (WB_ADR_I == OFS_WDOG) begin
      rd_data[15:0] = {presc_q, watchdog_counter_q};
    end else if (WB_ADR_I == OFS_CTRL) begin
      rd_data[CT_BUSY]   = pend_q | (state_q != ST_IDLE);
      rd_data[CT_ASLEEP] = (state_q == ST_ASLEEP);
    end
  end

  // one-wait-state ack, read data captured with it
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        rdat_q <= rd_data;
      end
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // core state pins, registered a cycle behind the sequencer
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SLEEP_O <= 1'b0;
      BUSY_O  <= 1'b0;
    end else begin
      SLEEP_O <= (state_q == ST_ASLEEP);
      BUSY_O  <= pend_q | (state_q != ST_IDLE);
    end
  end

  // checks
  chk_or_literal: assert property ( // RULE1
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_OR_LIT |=>
      acc_q == ($past(acc_q) | $past(lit)) &&
      null_flag_q == (($past(acc_q) | $past(lit)) == 8'h00))
    else $error("or literal result or null flag wrong");

  chk_or_file_dest: assert property ( // RULE2
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_OR_FILE && dest_file |=>
      file_q[$past(fadr)] == ($past(acc_q) | $past(fval)) &&
      $stable(acc_q))
    else $error("or file to file wrong");

  chk_store_acc: assert property ( // RULE3
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_STORE |=>
      file_q[$past(fadr)] == $past(acc_q) && $stable(null_flag_q) &&
      $stable(sleep_entered_flag_n_q))
    else $error("store accumulator wrong");

  chk_load_file: assert property ( // RULE4
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_LOAD_F && !dest_file |=>
      acc_q == $past(fval))
    else $error("load file to accumulator wrong");

  chk_self_test: assert property ( // RULE5
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_LOAD_F && dest_file |=>
      null_flag_q == ($past(fval) == 8'h00) && $stable(acc_q))
    else $error("self load null test wrong");

  chk_load_literal: assert property ( // RULE6
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_LOAD_LIT |=>
      acc_q == $past(lit) && $stable(null_flag_q))
    else $error("load literal wrong");

  chk_config_load: assert property ( // RULE7
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_CONFIG |=>
      config_q == $past(acc_q) && $stable(null_flag_q))
    else $error("config load wrong");

  chk_return_pc: assert property ( // RULE8
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_RET_LIT |=>
      pc_q == $past(stack_top_q) && acc_q == $past(lit))
    else $error("return target or literal wrong");

  chk_return_slot: assert property ( // RULE9
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_RET_LIT |=>
      !exec_go [*4] ##1 state_q == ST_IDLE)
    else $error("return did not take two cycles");

  chk_sleep_wdog: assert property ( // RULE10
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_SLEEP |=>
      watchdog_counter_q == WDOG_CLR && presc_q == WDOG_CLR)
    else $error("sleep did not clear watchdog");

  chk_sleep_flags: assert property ( // RULE11
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_SLEEP |=>
      watchdog_expiry_flag_n_q && !sleep_entered_flag_n_q &&
      $stable(pin_wake_flag_q))
    else $error("sleep flags wrong");

  chk_sleep_halt: assert property ( // RULE12
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    state_q == ST_ASLEEP |=>
      $stable(presc_q) && $stable(watchdog_counter_q) && div_q == 2'h0)
    else $error("core advanced while asleep");

  chk_nop_idle: assert property ( // RULE13
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    exec_go && opc == OPC_NOP |=>
      pc_q == $past(pc_q) + 9'h001 && $stable(acc_q) &&
      $stable(null_flag_q) && state_q == ST_IDLE)
    else $error("nop changed state");

  cov_return: cover property (@(posedge CORE_CLK_I)
    exec_go && opc == OPC_RET_LIT);
  cov_sleep_wake: cover property (@(posedge CORE_CLK_I)
    state_q == ST_ASLEEP ##1 state_q == ST_IDLE);
  cov_self_zero: cover property (@(posedge CORE_CLK_I)
    exec_go && opc == OPC_LOAD_F && dest_file && fval == 8'h00);

endmodule

// >>> rtl/exec_pkg.sv
// Purpose: constants shared by the instruction execution block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   instruction word is 12 bits: opcode, then operand field
package exec_pkg;

  // instruction word layout
  localparam int INSTR_W     = 12;
  localparam int OPC_MSB     = 11;
  localparam int OPC_LSB     = 8;
  localparam int DEST_BIT    = 5;
  localparam int FADR_MSB    = 4;
  localparam int DATA_W      = 8;
  localparam int FADR_W      = 5;
  localparam int PC_W        = 9;

  // opcode values (own encoding)
  localparam logic [3:0] OPC_NOP      = 4'h0;
  localparam logic [3:0] OPC_OR_LIT   = 4'h1;
  localparam logic [3:0] OPC_OR_FILE  = 4'h2;
  localparam logic [3:0] OPC_STORE    = 4'h3;
  localparam logic [3:0] OPC_LOAD_F   = 4'h4;
  localparam logic [3:0] OPC_LOAD_LIT = 4'h5;
  localparam logic [3:0] OPC_CONFIG   = 4'h6;
  localparam logic [3:0] OPC_RET_LIT  = 4'h7;
  localparam logic [3:0] OPC_SLEEP    = 4'h8;

  // register byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_PC     = 8'h10;
  localparam logic [7:0] OFS_STACK  = 8'h14;
  localparam logic [7:0] OFS_WDOG   = 8'h18;
  localparam logic [7:0] OFS_CTRL   = 8'h1C;
  localparam int         FILE_SEL_BIT = 7;

  // status field positions
  localparam int ST_NULL    = 0;
  localparam int ST_SLEEP_N = 3;
  localparam int ST_EXPIRY_N = 4;
  localparam int ST_PINWAKE = 7;
  // control/state field positions
  localparam int CT_WAKE    = 0;
  localparam int CT_BUSY    = 1;
  localparam int CT_ASLEEP  = 2;

  // reset and clear values, prescaler wrap point
  localparam logic [7:0]      ACC_RST    = 8'h00;
  localparam logic [7:0]      CONFIG_RST = 8'hFF;
  localparam logic [PC_W-1:0] PC_RST     = 9'h000;
  localparam logic [7:0]      FILE_RST   = 8'h00;
  localparam logic [7:0]      WDOG_CLR   = 8'h00;
  localparam logic [7:0]      PRESC_MAX  = 8'hFF;

  // core clocks per instruction cycle
  localparam int         CLK_PER_INSTR = 4;
  localparam logic [1:0] DIV_LAST      = 2'(CLK_PER_INSTR - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FLUSH,
    ST_ASLEEP
  } exec_state_t;

endpackage

// >>> sim/logic_move_sleep_instr_exec_tb.sv
// Purpose: self-checking bench for the instruction execution block
// Assumes: one-cycle wishbone ack; BUSY_O follows pending work
// Notes:   every expectation is worked out here from the opcode behaviour
`timescale 1ns/10ps
module logic_move_sleep_instr_exec_tb;
  import exec_pkg::*;

  // generous ceiling; the whole run needs well under 3000 clocks
  localparam int LIMIT = 20000;

  logic        clk;
  logic        rst_b;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        wake;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic        ack;
  logic        sleep;
  logic        busy;
  logic [8:0]  pc;
  int          fails;
  int          comparisons;
  int          cycles;
  int          n;

  instr_exec i_dut (
    .CORE_CLK_I (clk),
    .RST_B_I    (rst_b),
    .WB_CYC_I   (cyc),
    .WB_STB_I   (stb),
    .WB_WE_I    (we),
    .WB_ADR_I   (adr),
    .WB_SEL_I   (sel),
    .WB_DAT_I   (wdat),
    .WB_DAT_O   (dat_o),
    .WB_ACK_O   (ack),
    .WAKE_PIN_I (wake),
    .SLEEP_O    (sleep),
    .BUSY_O     (busy)
  );

  // free running core clock, 10 ns period
  always #5 clk = ~clk;

  // hang guard: a run that overshoots counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      $display("BAD timeout exp finish got hang");
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one classic cycle; entered just after an edge, left just after one
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    k = 0;
    // only the bench ceiling ends this wait; the slave sets the pace
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1);
    rdat = dat_o;
    chk("ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    // strobe stays low a full cycle so the slave cannot re-take it
    @(posedge clk);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, exp, rdat & m);
  endtask

  // post one word and count the cycles BUSY_O stays up (capped at 12)
  task automatic exec(input logic [3:0] op, input logic [7:0] k);
    wb(1'b1, OFS_INSTR, {20'h0, op, k});
    n = 0;
    while (busy === 1'b1 && n < 12) begin
      @(posedge clk);
      n++;
    end
  endtask

  function automatic logic [7:0] fa(input int f);
    return {1'b1, 5'(f), 2'b00};
  endfunction

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    wake = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // reset state and an unmapped hole
    rd_chk("acc", OFS_ACC, 32'hFFFFFFFF, 32'h00);
    rd_chk("config", OFS_CONFIG, 32'hFFFFFFFF, 32'hFF);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h18);
    wb(1'b1, 8'h20, 32'h55);
    rd_chk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    // a write without the low byte lane must be ignored
    sel <= 4'h0;
    wb(1'b1, OFS_ACC, 32'h77);
    sel <= 4'hF;
    rd_chk("acc lane", OFS_ACC, 32'hFFFFFFFF, 32'h00);
    $display("test reset done");
    // zero literal must not touch the null flag
    exec(OPC_LOAD_LIT, 8'h00);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'h00);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h18);
    exec(OPC_OR_LIT, 8'h00);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h19);
    exec(OPC_OR_LIT, 8'hA5);
    exec(OPC_OR_LIT, 8'h5A);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'hFF);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h18);
    $display("test literal done");
    // store to both ends of the file, null preset to catch stray updates
    wb(1'b1, OFS_STATUS, 32'h19);
    for (int f = 0; f < 32; f += 31) begin
      exec(OPC_STORE, 8'(f));
      rd_chk("file", fa(f), 32'hFF, 32'hFF);
    end
    rd_chk("status", OFS_STATUS, 32'h99, 32'h19);
    $display("test store done");
    // or with file, both destinations
    wb(1'b1, OFS_STATUS, 32'h18);
    wb(1'b1, fa(0), 32'h00);
    exec(OPC_LOAD_LIT, 8'h00);
    exec(OPC_OR_FILE, 8'h20);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h19);
    exec(OPC_LOAD_LIT, 8'h81);
    wb(1'b1, fa(0), 32'h0C);
    exec(OPC_OR_FILE, 8'h20);
    rd_chk("file", fa(0), 32'hFF, 32'h8D);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'h81);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h18);
    wb(1'b1, fa(31), 32'h30);
    exec(OPC_OR_FILE, 8'h1F);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'hB1);
    rd_chk("file", fa(31), 32'hFF, 32'h30);
    $display("test or file done");
    // self load acts as a zero test
    wb(1'b1, fa(5), 32'h00);
    exec(OPC_LOAD_F, 8'h25);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h19);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'hB1);
    wb(1'b1, fa(5), 32'h77);
    exec(OPC_LOAD_F, 8'h25);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h18);
    exec(OPC_LOAD_F, 8'h05);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'h77);
    wb(1'b1, fa(5), 32'h00);
    exec(OPC_LOAD_F, 8'h05);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'h00);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h19);
    $display("test load file done");
    // prescaler config copy
    exec(OPC_LOAD_LIT, 8'h2D);
    exec(OPC_CONFIG, 8'h00);
    rd_chk("config", OFS_CONFIG, 32'hFF, 32'h2D);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h19);
    // no-operation: one cycle, pc advances only
    wb(1'b0, OFS_PC, 32'h0);
    pc = rdat[8:0] + 9'h001;
    exec(OPC_NOP, 8'hFF);
    chk("nop cycles", 32'h1, 32'(n >= 1 && n <= 4));
    rd_chk("pc", OFS_PC, 32'h1FF, {23'h0, pc});
    rd_chk("acc", OFS_ACC, 32'hFF, 32'h2D);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h19);
    $display("test config nop done");
    // return: literal, pc from stack, one extra flushed cycle
    wb(1'b1, OFS_STATUS, 32'h18);
    wb(1'b1, OFS_STACK, 32'h1A5);
    exec(OPC_RET_LIT, 8'h00);
    chk("ret cycles", 32'h1, 32'(n >= 5 && n <= 8));
    rd_chk("acc", OFS_ACC, 32'hFF, 32'h00);
    rd_chk("pc", OFS_PC, 32'h1FF, 32'h1A5);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h18);
    $display("test return done");
    // sleep with flags preset opposite to what sleep must leave
    wb(1'b0, OFS_WDOG, 32'h0);
    chk("wdog run", 32'h1, 32'(rdat[15:0] != 16'h0));
    wb(1'b1, OFS_STATUS, 32'h89);
    exec(OPC_SLEEP, 8'h00);
    chk("sleep", 32'h1, {31'h0, sleep});
    chk("busy", 32'h1, {31'h0, busy});
    rd_chk("wdog", OFS_WDOG, 32'hFFFF, 32'h0);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h91);
    // a post while asleep is dropped and nothing advances
    exec(OPC_LOAD_LIT, 8'h99);
    repeat (40) @(posedge clk);
    rd_chk("wdog", OFS_WDOG, 32'hFFFF, 32'h0);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'h00);
    wb(1'b1, OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("sleep", 32'h0, {31'h0, sleep});
    rd_chk("status", OFS_STATUS, 32'h99, 32'h91);
    exec(OPC_LOAD_LIT, 8'h3C);
    rd_chk("acc", OFS_ACC, 32'hFF, 32'h3C);
    $display("test sleep soft wake done");
    // second sleep, woken by the pin this time
    wb(1'b1, OFS_STATUS, 32'h18);
    exec(OPC_SLEEP, 8'h00);
    rd_chk("status", OFS_STATUS, 32'h99, 32'h10);
    wake <= 1'b1;
    repeat (2) @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    chk("sleep", 32'h0, {31'h0, sleep});
    rd_chk("status", OFS_STATUS, 32'h99, 32'h90);
    $display("test sleep pin wake done");
    close_out();
  end
endmodule
